// *** common/dsilp_pkg.sv ***
/*
  Constants, field layouts and types for the interrupt and low-power block.
  Assumes one processor-cycle clock; the input clock runs at half its rate.
*/
package dsilp_pkg;
  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_MASK = 8'h00;
  localparam logic [7:0] OFS_CTRL = 8'h04;
  localparam logic [7:0] OFS_FORCE = 8'h08;
  localparam logic [7:0] OFS_CMD = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;
  localparam logic [7:0] OFS_VECTOR = 8'h14;
  // ==========================================================
  // sources, index equals priority (0 highest after reset)
  localparam int NUM_SRC = 11;
  localparam logic [13:0] VEC_RESET = 14'h0000;
  localparam logic [13:0] VEC_PWRDN = 14'h002C;
  localparam logic [3:0] LVL_NONE = 4'hF;
  localparam logic [10:0] MASK_RESET = 11'h001;
  localparam logic [8:0] CTRL_RESET = 9'h000;
  localparam int FORCE_CLR_LSB = 16;
  localparam int STATUS_GEN_BIT = 16;
  localparam int STATUS_IDLE_BIT = 17;
  localparam int STATUS_PD_BIT = 18;
  localparam int STATUS_DEPTH_LSB = 20;
  localparam int STATUS_OVF_BIT = 24;
  // ==========================================================
  // timing
  localparam int CYCLE_NS = 5;
  localparam int INCLK_NS = 2 * CYCLE_NS;
  localparam int WAKE_RUN_INCLK = 100;
  localparam int WAKE_XTAL_INCLK = 4096;
  localparam int WAKE_RUN_CYC = (WAKE_RUN_INCLK * INCLK_NS) / CYCLE_NS;
  localparam int WAKE_XTAL_CYC = (WAKE_XTAL_INCLK * INCLK_NS) / CYCLE_NS;
  localparam int IDLE_DIV_MIN = 16;
  localparam int STACK_LEVELS = 12;
  // ==========================================================
  typedef struct packed {
    logic ctx_clear;    // bit 8, also power-up context reset
    logic osc_off;      // bit 7
    logic clk_out_dis;  // bit 6
    logic sport_b_pins; // bit 5
    logic alt_b_edge;   // bit 4
    logic alt_a_edge;   // bit 3
    logic prog_a_edge;  // bit 2
    logic nested;       // bit 1
    logic rsvd;         // bit 0
  } dsilp_ctrl_t;

  typedef struct packed {
    logic pwr_down;  // bit 7
    logic ret;       // bit 6
    logic [2:0] div; // bits 5:3, 0 plain, 1..4 = 16..128
    logic wait_int;  // bit 2
    logic dis;       // bit 1
    logic ena;       // bit 0
  } dsilp_cmd_t;

  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_PD = 2'b01,
    ST_WAKE = 2'b11,
    ST_IDLE = 2'b10
  } dsilp_state_t;
endpackage

// *** verilog/dsilp_top.sv ***
/*
  Interrupt controller with idle, slow idle and power-down sequencing.
  Assumes pins synchronous to MCLK, an APB master and a sequencer that
  consumes vectors and pulses SEQ_PUSH/SEQ_POP for loops and calls.
*/
`timescale 1ns/10ps
module dsilp_top
  import dsilp_pkg::*;
#(
  parameter int WAKE_XTAL_CYCLES = WAKE_XTAL_CYC,
  parameter int STACK_DEPTH = STACK_LEVELS
) (
  input wire logic MCLK,
  input wire logic ARST_N,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic EXT_INT_PROG_A_N,
  input wire logic EXT_LEVEL_INT_A_N,
  input wire logic EXT_LEVEL_INT_B_N,
  input wire logic EXT_EDGE_INT_N,
  input wire logic SPORT_ALT_INT_A_N,
  input wire logic SPORT_ALT_INT_B_N,
  input wire logic SPA_TX_REQ,
  input wire logic SPA_RX_REQ,
  input wire logic SPB_TX_REQ,
  input wire logic SPB_RX_REQ,
  input wire logic BYTE_DMA_REQ,
  input wire logic TIMER_REQ,
  input wire logic SEQ_PUSH,
  input wire logic SEQ_POP,
  input wire logic POWERDOWN_REQUEST_N,
  output logic POWERDOWN_ACK,
  output logic [13:0] INT_VECTOR,
  output logic INT_VECTOR_STB,
  output logic CONTEXT_CLEAR,
  output logic DIV_CLK_EN,
  output logic PROCESSOR_CLOCK_OUT_EN
);
  // ==========================================================
  // elaboration checks
  if (WAKE_XTAL_CYCLES < 1 || WAKE_XTAL_CYCLES > 16383) begin : g_chk_wake
    $error("WAKE_XTAL_CYCLES out of range");
  end
  if (STACK_DEPTH < 1 || STACK_DEPTH > 15) begin : g_chk_stack
    $error("STACK_DEPTH out of range");
  end

  function automatic logic [13:0] vec_of(input logic [3:0] idx);
    vec_of = (idx == 4'd0) ? VEC_PWRDN : {8'h00, idx, 2'b00};
  endfunction

  function automatic logic [2:0] reg_sel(input logic [7:0] a);
    case (a)
      OFS_MASK: reg_sel = 3'd1;
      OFS_CTRL: reg_sel = 3'd2;
      OFS_FORCE: reg_sel = 3'd3;
      OFS_CMD: reg_sel = 3'd4;
      OFS_STATUS: reg_sel = 3'd5;
      OFS_VECTOR: reg_sel = 3'd6;
      default: reg_sel = 3'd0;
    endcase
  endfunction

  // ==========================================================
  // state
  logic [10:0] mask_reg;
  dsilp_ctrl_t ctrl_reg;
  logic gen_reg;
  logic block_reg;
  logic [10:0] lat_reg;
  logic [10:0] lat_next;
  logic [3:0] cur_lvl_reg;
  logic [3:0] depth_reg;
  logic ovf_reg;
  logic [3:0] stk_mem [STACK_DEPTH];
  dsilp_state_t state_reg;
  dsilp_state_t state_next;
  logic [2:0] div_reg;
  logic [6:0] slow_cnt_reg;
  logic [13:0] wake_cnt_reg;
  logic rst_vec_reg;
  logic [13:0] vec_reg;
  logic stb_reg;
  logic ctx_clr_reg;
  logic pd_by_pin_reg;
  logic [9:0] pin_prev_reg;
  logic [31:0] rdata_reg;
  logic slverr_reg;

  // ==========================================================
  // bus decode
  logic wr_acc;
  logic [2:0] wsel;
  dsilp_cmd_t cmd;
  assign wr_acc = CE && PSEL && PENABLE && PWRITE;
  assign wsel = reg_sel(PADDR);
  assign cmd = dsilp_cmd_t'(PWDATA[7:0]);

  logic mask_wr;
  logic ctrl_wr;
  logic force_wr;
  logic cmd_wr;
  assign mask_wr = wr_acc && wsel == 3'd1;
  assign ctrl_wr = wr_acc && wsel == 3'd2;
  assign force_wr = wr_acc && wsel == 3'd3;
  assign cmd_wr = wr_acc && wsel == 3'd4;

  // ==========================================================
  // request sensing
  logic [9:0] pins_n;
  logic [9:0] fall;
  logic [10:0] set_v;
  logic [10:0] level_v;
  logic [10:0] raw;
  assign pins_n = {POWERDOWN_REQUEST_N, SPORT_ALT_INT_B_N,
                   SPORT_ALT_INT_A_N, EXT_EDGE_INT_N, EXT_LEVEL_INT_A_N,
                   EXT_LEVEL_INT_B_N, EXT_INT_PROG_A_N, 3'b111};
  assign fall = pin_prev_reg & ~pins_n;

  always_comb begin
    set_v = '0;
    level_v = '0;
    set_v[0] = fall[9];
    set_v[1] = fall[3] && ctrl_reg.prog_a_edge;
    level_v[1] = !pins_n[3] && !ctrl_reg.prog_a_edge;
    level_v[2] = !pins_n[4];
    level_v[3] = !pins_n[5];
    set_v[4] = SPA_TX_REQ;
    set_v[5] = SPA_RX_REQ;
    set_v[6] = fall[6];
    set_v[7] = BYTE_DMA_REQ;
    set_v[10] = TIMER_REQ;
    if (ctrl_reg.sport_b_pins) begin
      set_v[8] = fall[8] && ctrl_reg.alt_b_edge;
      set_v[9] = fall[7] && ctrl_reg.alt_a_edge;
      level_v[8] = !pins_n[8] && !ctrl_reg.alt_b_edge;
      level_v[9] = !pins_n[7] && !ctrl_reg.alt_a_edge;
    end else begin
      set_v[8] = SPB_TX_REQ;
      set_v[9] = SPB_RX_REQ;
    end
    if (force_wr) begin
      set_v = set_v | PWDATA[10:0];
    end
  end

  assign raw = lat_reg | level_v;

  // ==========================================================
  // selection
  logic [10:0] elig;
  logic any_elig;
  logic [3:0] sel_idx;
  logic slow;
  logic tick;
  logic run_ok;
  logic take;
  logic full;

  assign slow = div_reg != 3'd0;
  assign tick = slow_cnt_reg == 7'd0;
  assign full = depth_reg == 4'(STACK_DEPTH);

  always_comb begin
    elig = raw & (mask_reg | MASK_RESET);
    for (int i = 0; i < NUM_SRC; i++) begin
      if (ctrl_reg.nested ? (4'(i) >= cur_lvl_reg)
                          : (cur_lvl_reg != LVL_NONE)) begin
        elig[i] = 1'b0;
      end
    end
  end

  always_comb begin
    sel_idx = 4'd0;
    for (int i = NUM_SRC - 1; i >= 0; i--) begin
      if (elig[i]) begin
        sel_idx = 4'(i);
      end
    end
  end

  assign any_elig = |elig;
  // slow idle answers only on a divided tick
  assign run_ok = state_reg == ST_RUN ||
                  (state_reg == ST_IDLE && (!slow || tick));
  assign take = CE && any_elig && gen_reg && !block_reg && run_ok &&
                !full && !rst_vec_reg;

  // ==========================================================
  // power-down sequencing
  logic pd_enter;
  logic wake_done;
  assign pd_enter = (cmd_wr && cmd.pwr_down) ||
                    (!pins_n[9] && !gen_reg);
  assign wake_done = state_reg == ST_WAKE && wake_cnt_reg == 14'd0;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      ST_RUN: begin
        if (pd_enter) begin
          state_next = ST_PD;
        end else if (cmd_wr && cmd.wait_int) begin
          state_next = ST_IDLE;
        end
      end
      ST_IDLE: begin
        if (pd_enter) begin
          state_next = ST_PD;
        end else if (take) begin
          state_next = ST_RUN;
        end
      end
      ST_PD: begin
        if (fall[9] || (pd_by_pin_reg && pins_n[9])) begin
          state_next = ST_WAKE;
        end
      end
      ST_WAKE: begin
        if (wake_done) begin
          state_next = ST_RUN;
        end
      end
      default: state_next = ST_RUN;
    endcase
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      state_reg <= ST_RUN;
    end else if (CE) begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pd_by_pin_reg <= 1'b0;
    end else if (CE && state_reg != ST_PD && state_next == ST_PD) begin
      pd_by_pin_reg <= !(cmd_wr && cmd.pwr_down);
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      wake_cnt_reg <= '0;
    end else if (CE) begin
      if (state_reg == ST_PD) begin
        wake_cnt_reg <= ctrl_reg.osc_off
          ? 14'(WAKE_XTAL_CYCLES - 1)
          : 14'(WAKE_RUN_CYC - 1);
      end else if (state_reg == ST_WAKE && wake_cnt_reg != 14'd0) begin
        wake_cnt_reg <= wake_cnt_reg - 14'd1;
      end
    end
  end

  logic ctx_wipe;
  assign ctx_wipe = CE && wake_done && ctrl_reg.ctx_clear;

  // ==========================================================
  // slow idle divider
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      div_reg <= '0;
      slow_cnt_reg <= '0;
    end else if (CE) begin
      if (state_reg == ST_RUN && cmd_wr && cmd.wait_int) begin
        div_reg <= (cmd.div > 3'd4) ? 3'd4 : cmd.div;
        slow_cnt_reg <= '0;
      end else if (state_reg == ST_IDLE && slow) begin
        slow_cnt_reg <= tick ? 7'((IDLE_DIV_MIN << (div_reg - 3'd1)) - 1)
                             : slow_cnt_reg - 7'd1;
      end else if (state_reg != ST_IDLE) begin
        div_reg <= '0;
      end
    end
  end

  // divided enable also slows serial clock and timer
  assign DIV_CLK_EN = state_reg == ST_RUN ||
                      (state_reg == ST_IDLE && (!slow || tick));
  assign PROCESSOR_CLOCK_OUT_EN = DIV_CLK_EN && !ctrl_reg.clk_out_dis;
  assign POWERDOWN_ACK = state_reg == ST_PD;

  // ==========================================================
  // registers written by software
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      mask_reg <= MASK_RESET;
      ctrl_reg <= dsilp_ctrl_t'(CTRL_RESET);
    end else begin
      if (mask_wr) begin
        mask_reg <= PWDATA[10:0];
      end
      if (ctrl_wr) begin
        ctrl_reg <= dsilp_ctrl_t'(PWDATA[8:0]);
      end
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      block_reg <= 1'b0;
    end else if (CE) begin
      block_reg <= mask_wr;
    end
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      gen_reg <= 1'b1;
    end else if (cmd_wr) begin
      if (cmd.dis) begin
        gen_reg <= 1'b0;
      end else if (cmd.ena) begin
        gen_reg <= 1'b1;
      end
    end
  end

  // ==========================================================
  // edge latches: a new event beats a clear in the same cycle
  always_comb begin
    lat_next = lat_reg;
    if (take) begin
      lat_next[sel_idx] = 1'b0;
    end
    if (force_wr) begin
      lat_next = lat_next & ~PWDATA[FORCE_CLR_LSB +: NUM_SRC];
    end
    if (ctx_wipe) begin
      lat_next = '0;
    end
    lat_next = lat_next | set_v;
  end

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      lat_reg <= '0;
      pin_prev_reg <= '1;
    end else if (CE) begin
      lat_reg <= lat_next;
      pin_prev_reg <= pins_n;
    end
  end

  // ==========================================================
  // status stack shared with loops and calls
  logic pop;
  assign pop = (cmd_wr && cmd.ret) || (CE && SEQ_POP);

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      depth_reg <= '0;
      cur_lvl_reg <= LVL_NONE;
      ovf_reg <= 1'b0;
    end else if (ctx_wipe) begin
      depth_reg <= '0;
      cur_lvl_reg <= LVL_NONE;
    end else if (take) begin
      depth_reg <= depth_reg + 4'd1;
      cur_lvl_reg <= sel_idx;
    end else if (pop && depth_reg != 4'd0) begin
      depth_reg <= depth_reg - 4'd1;
      cur_lvl_reg <= stk_mem[depth_reg - 4'd1];
    end else if (CE && SEQ_PUSH) begin
      if (full) begin
        ovf_reg <= 1'b1;
      end else begin
        depth_reg <= depth_reg + 4'd1;
      end
    end
  end

  always_ff @(posedge MCLK) begin
    if (ARST_N && !ctx_wipe && !full &&
        (take || (!pop && CE && SEQ_PUSH))) begin
      stk_mem[depth_reg] <= cur_lvl_reg;
    end
  end

  // ==========================================================
  // vector output
  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rst_vec_reg <= 1'b1;
      vec_reg <= VEC_RESET;
      stb_reg <= 1'b0;
      ctx_clr_reg <= 1'b0;
    end else if (CE) begin
      stb_reg <= take || (rst_vec_reg && state_reg == ST_RUN);
      ctx_clr_reg <= ctx_wipe;
      if (ctx_wipe) begin
        rst_vec_reg <= 1'b1;
      end else if (rst_vec_reg && state_reg == ST_RUN) begin
        rst_vec_reg <= 1'b0;
        vec_reg <= VEC_RESET;
      end else if (take) begin
        vec_reg <= vec_of(sel_idx);
      end
    end
  end

  assign INT_VECTOR = vec_reg;
  assign INT_VECTOR_STB = stb_reg;
  assign CONTEXT_CLEAR = ctx_clr_reg;

  // ==========================================================
  // APB read path, data fetched in the setup cycle
  logic [2:0] rsel;
  assign rsel = reg_sel(PADDR);

  always_ff @(posedge MCLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rdata_reg <= '0;
      slverr_reg <= 1'b0;
    end else if (CE && PSEL && !PENABLE) begin
      rdata_reg <= '0;
      slverr_reg <= rsel == 3'd0;
      if (!PWRITE) begin
        case (rsel)
          3'd1: rdata_reg <= {21'h0_0000, mask_reg};
          3'd2: rdata_reg <= {23'h00_0000, ctrl_reg};
          3'd5: rdata_reg <= {7'h00, ovf_reg, depth_reg, 1'b0,
                              state_reg == ST_PD, state_reg == ST_IDLE,
                              gen_reg, 5'h00, raw};
          3'd6: rdata_reg <= {18'h0_0000, vec_reg};
          default: rdata_reg <= '0;
        endcase
      end
    end
  end

  assign PRDATA = rdata_reg;
  assign PREADY = CE;
  assign PSLVERR = slverr_reg && PSEL && PENABLE;

  // ==========================================================
  // assertions
  priority_vector_a: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    take |=> INT_VECTOR_STB && INT_VECTOR == vec_of($past(sel_idx)) &&
             INT_VECTOR[1:0] == 2'b00 && INT_VECTOR <= 14'h002C)
    else $error("wrong vector for taken request");
  reset_vector_a: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    CE && rst_vec_reg && state_reg == ST_RUN |=>
      INT_VECTOR_STB && INT_VECTOR == 14'h0000 && !rst_vec_reg)
    else $error("reset vector not issued");
  pwrdn_nomask_a: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    take && sel_idx == 4'd0 |=> INT_VECTOR == 14'h002C)
    else $error("power-down vector wrong");
  mask_gate_a: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    take && sel_idx != 4'd0 |-> mask_reg[sel_idx] && raw[sel_idx])
    else $error("masked request taken");
  mask_block_a: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    CE && mask_wr ##1 CE |-> !take)
    else $error("service during mask write shadow");
  seq_mode_a: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    take && !ctrl_reg.nested |-> cur_lvl_reg == 4'hF)
    else $error("sequential mode preempted");
  global_dis_a: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    cmd_wr && cmd.dis |=> !gen_reg ##0 !take)
    else $error("service while globally disabled");
  edge_hold_a: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    CE && lat_reg[6] && !(take && sel_idx == 4'd6) && !force_wr &&
    !ctx_wipe |=> lat_reg[6])
    else $error("edge request lost");
  pd_force_a: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    cmd_wr && cmd.pwr_down && state_reg == ST_RUN |=> POWERDOWN_ACK)
    else $error("force bit did not enter power-down");
  wake_hold_a: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    CE && state_reg == ST_WAKE && wake_cnt_reg != 14'd0 |=>
      state_reg == ST_WAKE && !INT_VECTOR_STB)
    else $error("wake ended early");
  clk_out_dis_a: assert property (
    @(posedge MCLK) disable iff (!ARST_N)
    ctrl_reg.clk_out_dis |-> !PROCESSOR_CLOCK_OUT_EN)
    else $error("clock output not disabled");
endmodule // dsilp_top

// *** tb/dsilp_src_model.sv ***
/*
  Model of the interrupt sources outside the block: pins and peripherals.
  Assumes the bench raises a request bit and holds it until it is served.
*/
`timescale 1ns/10ps
module dsilp_src_model (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [10:0] req,
  input wire logic [1:0] alt,
  output logic pd_n,
  output logic prog_a_n,
  output logic lvl_b_n,
  output logic lvl_a_n,
  output logic edge_n,
  output logic alt_a_n,
  output logic alt_b_n,
  output logic [5:0] per_req
);
  logic [10:0] req_reg;
  logic [1:0] alt_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_reg <= '0;
      alt_reg <= '0;
    end else begin
      req_reg <= req;
      alt_reg <= alt;
    end
  end

  // pins have pull-ups, so a released pin reads high
  assign pd_n = ~req_reg[0];
  assign prog_a_n = ~req_reg[1];
  assign lvl_b_n = ~req_reg[2];
  assign lvl_a_n = ~req_reg[3];
  assign edge_n = ~req_reg[6];
  assign alt_a_n = ~alt_reg[0];
  assign alt_b_n = ~alt_reg[1];
  // one pulse per event; a new one only after the request bit drops and rises again
  assign per_req = {req[10:7], req[5:4]} & ~{req_reg[10:7], req_reg[5:4]};
endmodule // dsilp_src_model

// *** tb/dsp_interrupt_and_low_power_control_tb.sv ***
/*
  Self-checking bench for the interrupt and low-power block.
  Assumes the package and dsilp_top; the source model drives the pins.
*/
`timescale 1ns/10ps
module dsp_interrupt_and_low_power_control_tb;
  import dsilp_pkg::*;
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin errors++; \
  $display("Error t=%0t got=%h exp=%h", $time, a, b); end end
  typedef struct packed {
    logic [10:0] mask;
    logic [10:0] src;
    logic [13:0] vec;
  } dsilp_row_t;
  localparam logic [13:0] NONE = 14'h3FFF;
  logic mclk, arst_n, psel, penable, pwrite, pready, pslverr, ack, stb;
  logic ctx, divclk, ckout, pd_n, pa_n, lb_n, la_n, e_n, aa_n, ab_n, er, got;
  logic ce, push;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [13:0] vec;
  logic [10:0] src;
  logic [1:0] alt;
  logic [5:0] per;
  dsilp_row_t rows [13];
  int errors, cmp_count, i, k, n;

  dsilp_src_model src_m (.clk(mclk), .rst_n(arst_n), .req(src), .alt(alt),
    .pd_n(pd_n), .prog_a_n(pa_n), .lvl_b_n(lb_n), .lvl_a_n(la_n),
    .edge_n(e_n), .alt_a_n(aa_n), .alt_b_n(ab_n), .per_req(per));

  // short crystal wait keeps the run brief
  dsilp_top #(.WAKE_XTAL_CYCLES(20), .STACK_DEPTH(12)) uut (.MCLK(mclk),
    .ARST_N(arst_n), .CE(ce), .PSEL(psel), .PENABLE(penable),
    .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
    .PREADY(pready), .PSLVERR(pslverr), .EXT_INT_PROG_A_N(pa_n),
    .EXT_LEVEL_INT_A_N(la_n), .EXT_LEVEL_INT_B_N(lb_n), .EXT_EDGE_INT_N(e_n),
    .SPORT_ALT_INT_A_N(aa_n), .SPORT_ALT_INT_B_N(ab_n), .SPA_TX_REQ(per[0]),
    .SPA_RX_REQ(per[1]), .SPB_TX_REQ(per[3]), .SPB_RX_REQ(per[4]),
    .BYTE_DMA_REQ(per[2]), .TIMER_REQ(per[5]), .SEQ_PUSH(push),
    .SEQ_POP(1'b0), .POWERDOWN_REQUEST_N(pd_n), .POWERDOWN_ACK(ack),
    .INT_VECTOR(vec), .INT_VECTOR_STB(stb), .CONTEXT_CLEAR(ctx),
    .DIV_CLK_EN(divclk), .PROCESSOR_CLOCK_OUT_EN(ckout));

  // ==========================================================
  // tasks
  task automatic test_done;
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_stb(input int lim);
    got = 1'b0;
    for (int j = 0; j < lim && !got; j++) begin
      @(posedge mclk);
      #1;
      got = (stb === 1'b1);
    end
  endtask

  task automatic do_reset;
    @(posedge mclk);
    arst_n <= 1'b0;
    @(posedge mclk);
    #1;
    `CHK(ack, 1'b0)
    repeat (7) @(posedge mclk);
    arst_n <= 1'b1;
    wait_stb(10);
    `CHK(vec, VEC_RESET)
  endtask

  task automatic ret;
    apb(1'b1, OFS_CMD, 32'h0000_0040);
  endtask

  // ==========================================================
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  initial begin
    #200_000;
    errors++;
    test_done;
  end

  initial begin
    {arst_n, psel, penable, pwrite, paddr, pwdata, src, alt, push} = '0;
    ce = 1'b1;
    errors = 0;
    cmp_count = 0;
    for (i = 0; i < 11; i++) begin
      rows[i] = '{11'(1 << i) | 11'h001, 11'(1 << i),
                  (i == 0) ? VEC_PWRDN : 14'(4 * i)};
    end
    rows[11] = '{11'h7FF, 11'h00C, 14'h0008};
    rows[12] = '{11'h001, 11'h008, NONE};
    do_reset;
    apb(1'b0, OFS_MASK, '0);
    `CHK(rd, 32'h0000_0001)
    apb(1'b0, OFS_STATUS, '0);
    `CHK(rd[STATUS_GEN_BIT], 1'b1)
    apb(1'b0, 8'h20, '0);
    `CHK({er, rd}, 33'h1_0000_0000)
    for (i = 0; i < 13; i++) begin
      apb(1'b1, OFS_MASK, {21'h0, rows[i].mask});
      src <= rows[i].src;
      wait_stb(40);
      `CHK(got ? vec : NONE, rows[i].vec)
      src <= '0;
      repeat (3) @(posedge mclk);
      if (got) ret;
    end
    // global disable holds forced requests; clear undoes a force
    apb(1'b1, OFS_MASK, 32'h0000_07FF);
    apb(1'b1, OFS_CMD, 32'h0000_0002);
    apb(1'b1, OFS_FORCE, 32'h0000_0400);
    wait_stb(20);
    `CHK(got, 1'b0)
    apb(1'b1, OFS_FORCE, 32'h0400_0080);
    apb(1'b1, OFS_CMD, 32'h0000_0001);
    wait_stb(20);
    `CHK(vec, 14'h001C)
    ret;
    apb(1'b1, OFS_CTRL, 32'h0000_0060);
    #1;
    `CHK(ckout, 1'b0)
    alt <= 2'b10;
    wait_stb(20);
    `CHK(vec, 14'h0020)
    alt <= 2'b00;
    ret;
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    // nested: edge pin preempts the timer handler
    apb(1'b1, OFS_CTRL, 32'h0000_0002);
    src <= 11'h400;
    wait_stb(20);
    `CHK(vec, 14'h0028)
    src <= 11'h040;
    wait_stb(20);
    `CHK(vec, 14'h0018)
    src <= '0;
    ret;
    ret;
    apb(1'b1, OFS_CTRL, 32'h0000_0000);
    // frozen clock enable holds the edge until it runs again
    ce <= 1'b0;
    src <= 11'h040;
    wait_stb(8);
    `CHK(got, 1'b0)
    ce <= 1'b1;
    wait_stb(8);
    `CHK(vec, 14'h0018)
    src <= '0;
    ret;
    // plain idle
    apb(1'b1, OFS_CMD, 32'h0000_0004);
    apb(1'b0, OFS_STATUS, '0);
    `CHK({rd[STATUS_IDLE_BIT], divclk}, 2'b11)
    src <= 11'h400;
    wait_stb(8);
    `CHK(vec, 14'h0028)
    src <= '0;
    ret;
    // slow idle: one clock tick per 16 cycles, wake on the timer
    apb(1'b1, OFS_CMD, 32'h0000_000C);
    n = 0;
    repeat (64) begin
      @(posedge mclk);
      #1;
      n += (divclk === 1'b1);
    end
    `CHK(n, 4)
    src <= 11'h400;
    wait_stb(20);
    `CHK(vec, 14'h0028)
    src <= '0;
    ret;
    for (k = 0; k < 2; k++) begin
      apb(1'b1, OFS_CTRL, k ? 32'h0000_0180 : 32'h0);
      apb(1'b1, OFS_CMD, 32'h0000_0080);
      repeat (2) @(posedge mclk);
      #1;
      `CHK({ack, divclk}, 2'b10)
      src <= 11'h001;
      n = 0;
      while (divclk !== 1'b1 && n < 9000) begin
        @(posedge mclk);
        #1;
        n++;
      end
      if (k == 0) `CHK(n >= 195 && n <= 204, 1'b1)
      else `CHK(n >= 16 && n <= 24, 1'b1)
      `CHK(ctx, k[0])
      src <= '0;
      wait_stb(20);
      `CHK(vec, k ? VEC_RESET : VEC_PWRDN)
      if (got) ret;
    end
    // a full stack refuses service
    push <= 1'b1;
    repeat (12) @(posedge mclk);
    push <= 1'b0;
    src <= 11'h400;
    wait_stb(20);
    `CHK(got, 1'b0)
    apb(1'b0, OFS_STATUS, '0);
    `CHK(rd[STATUS_DEPTH_LSB +: 4], 4'(STACK_LEVELS))
    src <= '0;
    apb(1'b1, OFS_CMD, 32'h0000_0080);
    repeat (3) @(posedge mclk);
    do_reset;
    test_done;
  end
endmodule // dsp_interrupt_and_low_power_control_tb
